// ===== verilog/gpt_top.sv
// Notes on behaviour
// - New load enters running counter immediately, but in full-width only on the low-word write
// - Full-width load is one 64-bit value
// - Load readback returns programmed value
// - 32-bit access serves half modes
// - Full-width uses first half's settings
// - Capture count match raises interrupt
// - PWM duty set by match value
// - Prescaler acts only in half-width
// - Prescale match extends the match range
// - RTC enable starts counting in RTC
// - RTC enable ignored outside RTC mode
// - Clearing RTC enable halts counting
// - Present count readable, also 64-bit
// - Only enabled sources reach interrupt line
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "gpt_map.svh"
module gpt_top import gpt_pkg::*; (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Capture pins
  input  wire logic        ccp_a,
  input  wire logic        ccp_b,
  // Outputs
  output logic             pwm_a,
  output logic             pwm_b,
  output logic             irq
);

  gpt_st_t     st_ff;
  gpt_st_t     nxt_st;
  logic [63:0] count_a;
  logic [47:0] count_b;
  logic [63:0] load_a_w;
  logic [63:0] match_a_w;
  logic        run_a;
  logic        run_b;
  logic        edge_a;
  logic        edge_b;
  logic        tmo_a;
  logic        tmo_b;
  logic        hit_a;
  logic        hit_b;
  logic        setup;
  logic        wr;
  irq_bits_t   ev;
  irq_bits_t   clr;

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `GPT_OFF_CFG, `GPT_OFF_LOAD_A, `GPT_OFF_LOAD_B, `GPT_OFF_MATCH_A, `GPT_OFF_MATCH_B,
      `GPT_OFF_PRE_A, `GPT_OFF_PRE_B, `GPT_OFF_PMAT_A, `GPT_OFF_PMAT_B, `GPT_OFF_VALUE_A,
      `GPT_OFF_VALUE_B, `GPT_OFF_RIS, `GPT_OFF_IMR, `GPT_OFF_MIS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  function automatic logic run_of(input tmode_t m, input logic en, input logic rtc_en);
    run_of = (m == MODE_RTC) ? (en && rtc_en) : en;
  endfunction

  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite && addr_ok(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata  = st_ff.rdata;

  // Edge detect reads only settled stages
  assign edge_a = st_ff.ccp_a_s[1] && !st_ff.ccp_a_s[2];
  assign edge_b = st_ff.ccp_b_s[1] && !st_ff.ccp_b_s[2];

  assign run_a = run_of(st_ff.cfg.mode_a, st_ff.cfg.en_a, st_ff.cfg.rtc_en);
  assign run_b = !st_ff.cfg.full && run_of(st_ff.cfg.mode_b, st_ff.cfg.en_b, st_ff.cfg.rtc_en);

  always_comb begin
    if (st_ff.cfg.full) begin
      load_a_w  = {st_ff.load_b, st_ff.load_a};
      match_a_w = {st_ff.match_b, st_ff.match_a};
    end else begin
      load_a_w  = {16'h0000, st_ff.pre_a, st_ff.load_a};
      match_a_w = {16'h0000, st_ff.pm_a, st_ff.match_a};
    end
  end

  count_unit #(
    .W (64)
  ) u_unit_a (
    .pclk      (pclk),
    .presetn   (presetn),
    .mode      (st_ff.cfg.mode_a),
    .run       (run_a),
    .reload    (st_ff.reload_a),
    .edge_in   (edge_a),
    .load_val  (load_a_w),
    .match_val (match_a_w),
    .count     (count_a),
    .timeout   (tmo_a),
    .match_hit (hit_a),
    .pwm       (pwm_a)
  );

  count_unit #(
    .W (48)
  ) u_unit_b (
    .pclk      (pclk),
    .presetn   (presetn),
    .mode      (st_ff.cfg.mode_b),
    .run       (run_b),
    .reload    (st_ff.reload_b),
    .edge_in   (edge_b),
    .load_val  ({st_ff.pre_b, st_ff.load_b}),
    .match_val ({st_ff.pm_b, st_ff.match_b}),
    .count     (count_b),
    .timeout   (tmo_b),
    .match_hit (hit_b),
    .pwm       (pwm_b)
  );

  always_comb begin
    ev         = '0;
    ev.a_tmo   = tmo_a;
    ev.a_match = hit_a && (st_ff.cfg.mode_a != MODE_RTC);
    ev.rtc     = hit_a && (st_ff.cfg.mode_a == MODE_RTC);
    ev.b_tmo   = tmo_b;
    ev.b_match = hit_b;
    clr        = '0;
    if (wr && (paddr == `GPT_OFF_RIS)) begin
      clr = irq_bits_t'(pwdata[`GPT_IRQ_W-1:0]);
    end
  end

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.reload_a = 1'b0;
    nxt_st.reload_b = 1'b0;
    nxt_st.ccp_a_s  = {st_ff.ccp_a_s[1:0], ccp_a};
    nxt_st.ccp_b_s  = {st_ff.ccp_b_s[1:0], ccp_b};
    // Set beats a same-cycle clear
    nxt_st.ris      = (st_ff.ris & ~clr) | ev;
    if (setup) begin
      case (paddr)
        `GPT_OFF_CFG:     nxt_st.rdata = {24'h000000, st_ff.cfg};
        `GPT_OFF_LOAD_A:  nxt_st.rdata = st_ff.load_a;
        `GPT_OFF_LOAD_B:  nxt_st.rdata = st_ff.load_b;
        `GPT_OFF_MATCH_A: nxt_st.rdata = st_ff.match_a;
        `GPT_OFF_MATCH_B: nxt_st.rdata = st_ff.match_b;
        `GPT_OFF_PRE_A:   nxt_st.rdata = {16'h0000, st_ff.pre_a};
        `GPT_OFF_PRE_B:   nxt_st.rdata = {16'h0000, st_ff.pre_b};
        `GPT_OFF_PMAT_A:  nxt_st.rdata = {16'h0000, st_ff.pm_a};
        `GPT_OFF_PMAT_B:  nxt_st.rdata = {16'h0000, st_ff.pm_b};
        `GPT_OFF_VALUE_A: begin
          nxt_st.rdata = count_a[31:0];
          nxt_st.snap  = count_a[63:32];
        end
        `GPT_OFF_VALUE_B: nxt_st.rdata = st_ff.cfg.full ? st_ff.snap : count_b[31:0];
        `GPT_OFF_RIS:     nxt_st.rdata = {27'h0000000, st_ff.ris};
        `GPT_OFF_IMR:     nxt_st.rdata = {27'h0000000, st_ff.imr};
        `GPT_OFF_MIS:     nxt_st.rdata = {27'h0000000, st_ff.ris & st_ff.imr};
        default:          nxt_st.rdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (paddr)
        `GPT_OFF_CFG:     nxt_st.cfg = cfg_t'(pwdata[`GPT_CFG_W-1:0]);
        `GPT_OFF_LOAD_A: begin
          nxt_st.load_a   = pwdata;
          nxt_st.reload_a = 1'b1;
        end
        `GPT_OFF_LOAD_B: begin
          nxt_st.load_b   = pwdata;
          // Upper word waits for the low word in full-width
          nxt_st.reload_b = !st_ff.cfg.full;
        end
        `GPT_OFF_MATCH_A: nxt_st.match_a = pwdata;
        `GPT_OFF_MATCH_B: nxt_st.match_b = pwdata;
        `GPT_OFF_PRE_A:   nxt_st.pre_a   = pwdata[`GPT_PRE_W-1:0];
        `GPT_OFF_PRE_B:   nxt_st.pre_b   = pwdata[`GPT_PRE_W-1:0];
        `GPT_OFF_PMAT_A:  nxt_st.pm_a    = pwdata[`GPT_PRE_W-1:0];
        `GPT_OFF_PMAT_B:  nxt_st.pm_b    = pwdata[`GPT_PRE_W-1:0];
        `GPT_OFF_IMR:     nxt_st.imr     = irq_bits_t'(pwdata[`GPT_IRQ_W-1:0]);
        default: begin
          nxt_st.imr = st_ff.imr;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff     <= '0;
      st_ff.cfg <= cfg_t'(`GPT_CFG_RST);
      st_ff.imr <= irq_bits_t'(`GPT_IMR_RST);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign irq = |(st_ff.ris & st_ff.imr);

endmodule

// ===== verilog/gpt_map.svh
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH

// Register byte offsets
`define GPT_OFF_CFG     8'h00
`define GPT_OFF_LOAD_A  8'h08
`define GPT_OFF_LOAD_B  8'h0C
`define GPT_OFF_MATCH_A 8'h10
`define GPT_OFF_MATCH_B 8'h14
`define GPT_OFF_PRE_A   8'h18
`define GPT_OFF_PRE_B   8'h1C
`define GPT_OFF_PMAT_A  8'h20
`define GPT_OFF_PMAT_B  8'h24
`define GPT_OFF_VALUE_A 8'h28
`define GPT_OFF_VALUE_B 8'h2C
`define GPT_OFF_RIS     8'h30
`define GPT_OFF_IMR     8'h34
`define GPT_OFF_MIS     8'h38

// Field widths and reset values
`define GPT_CFG_W       8
`define GPT_IRQ_W       5
`define GPT_PRE_W       16
`define GPT_CFG_RST     8'h00
`define GPT_IMR_RST     5'h00

`endif

// ===== verilog/gpt_pkg.sv
package gpt_pkg;

  typedef enum logic [1:0] {
    MODE_PERIODIC,
    MODE_CAPCNT,
    MODE_PWM,
    MODE_RTC
  } tmode_t;

  // Bit 0 is full
  typedef struct packed {
    logic   rtc_en;
    logic   en_b;
    logic   en_a;
    tmode_t mode_b;
    tmode_t mode_a;
    logic   full;
  } cfg_t;

  // Bit 0 is a_tmo
  typedef struct packed {
    logic b_match;
    logic b_tmo;
    logic rtc;
    logic a_match;
    logic a_tmo;
  } irq_bits_t;

  typedef struct packed {
    cfg_t        cfg;
    logic [31:0] load_a;
    logic [31:0] load_b;
    logic [31:0] match_a;
    logic [31:0] match_b;
    logic [15:0] pre_a;
    logic [15:0] pre_b;
    logic [15:0] pm_a;
    logic [15:0] pm_b;
    logic [31:0] snap;
    irq_bits_t   ris;
    irq_bits_t   imr;
    logic        reload_a;
    logic        reload_b;
    logic [31:0] rdata;
    logic [2:0]  ccp_a_s;
    logic [2:0]  ccp_b_s;
  } gpt_st_t;

endpackage

// ===== verilog/count_unit.sv
`timescale 1ns/100ps
module count_unit import gpt_pkg::*; #(
  parameter int W = 48
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire tmode_t       mode,
  input  wire logic         run,
  input  wire logic         reload,
  input  wire logic         edge_in,
  input  wire logic [W-1:0] load_val,
  input  wire logic [W-1:0] match_val,
  // Status
  output logic      [W-1:0] count,
  output logic              timeout,
  output logic              match_hit,
  output logic              pwm
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tmo;
    logic         hit;
    logic         pwm;
  } unit_st_t;

  unit_st_t st_ff;
  unit_st_t nxt_st;
  logic [W-1:0] dec;
  logic [W-1:0] inc;

  assign dec = st_ff.cnt - W'(1);
  assign inc = st_ff.cnt + W'(1);

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.tmo = 1'b0;
    nxt_st.hit = 1'b0;
    if (reload) begin
      nxt_st.cnt = load_val;
    end else if (run) begin
      case (mode)
        MODE_PERIODIC, MODE_PWM: begin
          nxt_st.tmo = (st_ff.cnt == '0);
          nxt_st.cnt = (st_ff.cnt == '0) ? load_val : dec;
        end
        MODE_CAPCNT: begin
          if (edge_in) begin
            nxt_st.tmo = (st_ff.cnt == '0);
            nxt_st.cnt = (st_ff.cnt == '0) ? load_val : dec;
            nxt_st.hit = (st_ff.cnt != '0) && (dec == match_val);
          end
        end
        MODE_RTC: begin
          nxt_st.cnt = inc;
          nxt_st.hit = (inc == match_val);
        end
        default: begin
          nxt_st.cnt = st_ff.cnt;
        end
      endcase
    end
    nxt_st.pwm = (mode == MODE_PWM) && run && (nxt_st.cnt > match_val);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count     = st_ff.cnt;
  assign timeout   = st_ff.tmo;
  assign match_hit = st_ff.hit;
  assign pwm       = st_ff.pwm;

endmodule

// ===== tb/gpt_top_props.sv
`timescale 1ns/100ps
`include "gpt_map.svh"
module gpt_top_props import gpt_pkg::*; (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Outputs
  input wire logic        pwm_a,
  input wire logic        pwm_b,
  input wire logic        irq
);
  logic [31:0] ld_ff, mt_ff;
  cfg_t        cf_ff;
  logic [4:0]  im_ff;
  wire         wa = psel && penable && pwrite;
  wire         ra = psel && penable && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of what software wrote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_ff <= '0;
      mt_ff <= '0;
      cf_ff <= '0;
      im_ff <= '0;
    end else if (wa) begin
      if (paddr == `GPT_OFF_LOAD_A) ld_ff <= pwdata;
      if (paddr == `GPT_OFF_MATCH_A) mt_ff <= pwdata;
      if (paddr == `GPT_OFF_CFG) cf_ff <= pwdata[7:0];
      if (paddr == `GPT_OFF_IMR) im_ff <= pwdata[4:0];
    end
  end
  load_rb_a: assert property (ra && paddr == `GPT_OFF_LOAD_A |-> prdata == ld_ff)
    else $error("load readback differs");
  match_rb_a: assert property (ra && paddr == `GPT_OFF_MATCH_A |-> prdata == mt_ff)
    else $error("match readback differs");
  irq_mask_a: assert property (wa && paddr == `GPT_OFF_IMR && pwdata[4:0] == 5'h00 |=> !irq)
    else $error("irq high with all sources masked");
  irq_rise_a: assert property ($rose(irq) |-> im_ff != 5'h00)
    else $error("irq rose with no enabled source");
  // Registered output may lag the mode by a cycle
  pwm_a_off_a: assert property ((cf_ff.mode_a != MODE_PWM) [*3] |-> !pwm_a)
    else $error("pwm_a active outside pwm mode");
  pwm_b_off_a: assert property ((cf_ff.mode_b != MODE_PWM) [*3] |-> !pwm_b)
    else $error("pwm_b active outside pwm mode");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase not answered");
  unmapped_a: assert property (psel && penable && paddr == 8'h04 |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
endmodule

bind gpt_top gpt_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pwm_a(pwm_a), .pwm_b(pwm_b), .irq(irq));

// ===== tb/gpt_top_bench.sv
`timescale 1ns/100ps
`include "gpt_map.svh"
module gpt_top_bench;
  logic        pclk, presetn, psel, penable, pwrite, ccp_a, ccp_b, perr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rv, v1;
  wire  [31:0] prdata;
  wire         pready, pslverr, pwm_a, pwm_b, irq;
  int          fails, n_tests, cyc, hi;
  logic [7:0]  oa [6] = '{`GPT_OFF_LOAD_A, `GPT_OFF_LOAD_B, `GPT_OFF_MATCH_A,
                          `GPT_OFF_MATCH_B, `GPT_OFF_PRE_A, `GPT_OFF_PMAT_A};
  logic [31:0] ov [6] = '{32'hA5A5_0F0F, 32'h5A5A_F0F0, 32'h1234_5678,
                          32'h8765_4321, 32'h0000_FFFF, 32'h0000_00FF};
  logic [7:0]  rt [3] = '{8'h80, 8'hA6, 8'h26};

  gpt_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ccp_a(ccp_a), .ccp_b(ccp_b), .pwm_a(pwm_a), .pwm_b(pwm_b), .irq(irq));

  always #50 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  task conclude;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    ap(1'b1, a, d);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e);
    ap(1'b0, a, 32'h0000_0000);
    chk(rv, e);
  endtask

  task rd_pair;
    ap(1'b0, `GPT_OFF_VALUE_A, 32'h0000_0000);
    v1 = rv;
    ap(1'b0, `GPT_OFF_VALUE_B, 32'h0000_0000);
  endtask

  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    ccp_a = 0;
    ccp_b = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rc(`GPT_OFF_CFG, {24'h0, `GPT_CFG_RST});
    rc(`GPT_OFF_IMR, {27'h0, `GPT_IMR_RST});
    // Prescale values stay inside the 16-bit field
    for (int i = 0; i < 6; i++) wr(oa[i], ov[i]);
    for (int i = 0; i < 6; i++) rc(oa[i], ov[i]);
    ap(1'b0, 8'h04, 32'h0000_0000);
    chk({31'h0, perr}, 32'h1);
    wr(`GPT_OFF_PRE_A, 32'h0000_0000);
    wr(`GPT_OFF_LOAD_A, 32'h8000_0000);
    wr(`GPT_OFF_CFG, 32'h0000_0020);
    wr(`GPT_OFF_LOAD_A, 32'h0000_1000);
    repeat (3) @(posedge pclk);
    rd_pair();
    chk(32'(v1 <= 32'h1000 && v1 > 32'hFF0), 32'h1);
    // Timer B was loaded but never enabled
    chk(rv, 32'h5A5A_F0F0);
    ap(1'b0, `GPT_OFF_VALUE_A, 32'h0000_0000);
    chk(32'(rv < v1), 32'h1);
    // Lower word wraps near the reads, so the pair must agree
    wr(`GPT_OFF_CFG, 32'h0000_0021);
    wr(`GPT_OFF_LOAD_B, 32'h0000_0005);
    wr(`GPT_OFF_LOAD_A, 32'h0000_0004);
    repeat (3) @(posedge pclk);
    rd_pair();
    chk(32'(rv == 5 && v1 <= 6 || rv == 4 && v1 > 32'hFFFF_FF00), 32'h1);
    repeat (20) @(posedge pclk);
    rd_pair();
    chk(rv, 32'h0000_0004);
    // Half mode first, so the reload takes the short value
    wr(`GPT_OFF_CFG, 32'h0000_0020);
    wr(`GPT_OFF_LOAD_A, 32'h0000_0010);
    repeat (40) @(posedge pclk);
    ap(1'b0, `GPT_OFF_RIS, 32'h0000_0000);
    chk({31'h0, rv[0]}, 32'h1);
    rc(`GPT_OFF_MIS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    wr(`GPT_OFF_IMR, 32'h0000_0001);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(`GPT_OFF_CFG, 32'h0000_0000);
    wr(`GPT_OFF_RIS, 32'h0000_001F);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`GPT_OFF_PMAT_A, 32'h0000_0000);
    wr(`GPT_OFF_MATCH_A, 32'h0000_0003);
    wr(`GPT_OFF_LOAD_A, 32'h0000_0005);
    wr(`GPT_OFF_CFG, 32'h0000_0022);
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      ccp_a <= 1'b1;
      repeat (3) @(posedge pclk);
      ccp_a <= 1'b0;
      repeat (4) @(posedge pclk);
      ap(1'b0, `GPT_OFF_RIS, 32'h0000_0000);
      chk({31'h0, rv[1]}, 32'(i));
    end
    wr(`GPT_OFF_LOAD_A, 32'h0000_0040);
    wr(`GPT_OFF_CFG, 32'h0000_0024);
    // Two whole periods of 65 cycles
    for (int m = 16; m < 64; m += 32) begin
      wr(`GPT_OFF_MATCH_A, 32'(m));
      hi = 0;
      repeat (130) begin
        @(posedge pclk);
        hi += int'(pwm_a === 1'b1);
      end
      chk(32'(hi > 2 * (64 - m) - 3 && hi < 2 * (64 - m) + 3), 32'h1);
    end
    wr(`GPT_OFF_LOAD_A, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr(`GPT_OFF_CFG, {24'h0, rt[i]});
      ap(1'b0, `GPT_OFF_VALUE_A, 32'h0000_0000);
      v1 = rv;
      ap(1'b0, `GPT_OFF_VALUE_A, 32'h0000_0000);
      chk(32'(rv != v1), 32'(i == 1));
    end
    conclude();
  end
endmodule
